// *** rtl/tmb_timer.sv ***
// 16-bit timer with buffered byte access behind an apb slave
// assumes an apb master, a crystal oscillator macro driven by osc_enable,
// and external count inputs that are plain levels
`timescale 1ns/1ps
module tmb_timer
   import tmb_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clk_in,
   input  wire logic        osc_clk_in,
   input  wire logic        sleep,
   input  wire logic        special_trigger,
   output logic             osc_enable,
   output logic             overflow_flag,
   output logic             irq,
   output logic             wake,
   output logic             conv_start
);
   typedef struct packed {
      logic [15:0] count;
      logic [7:0]  hbuf;
      logic [2:0]  presc;
      logic [10:0] ctrl;
      logic [15:0] cmp;
      logic [3:0]  cmp_mode;
      logic        ovf;
      logic        conv;
   } tmb_state_t;
   tmb_state_t st, next_st;

   logic instr_tick;
   logic ext_rise;
   logic osc_rise;

   tmb_clkdiv u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (instr_tick)
   );
   tmb_edge u_ext (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_clk_in),
      .rise    (ext_rise)
   );
   tmb_edge u_osc (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (osc_clk_in),
      .rise    (osc_rise)
   );

   // prescaler terminal count for the 1:1 .. 1:8 ratios
   function automatic logic [2:0] ps_last(input logic [1:0] ps);
      case (ps)
         2'b00:   ps_last = 3'h0;
         2'b01:   ps_last = 3'h1;
         2'b10:   ps_last = 3'h3;
         default: ps_last = 3'h7;
      endcase
   endfunction

   logic        acc;
   logic        wr;
   logic        rd;
   logic        wide;
   logic        src_edge;
   logic        async_mode;
   logic        can_inc;
   logic        presc_done;
   logic        trig_reset;

   assign acc        = psel & penable;
   assign wr         = acc & pwrite;
   assign rd         = acc & ~pwrite;
   assign wide       = st.ctrl[CTRL_WIDE];
   assign async_mode = st.ctrl[CTRL_CS] & st.ctrl[CTRL_SYNCN];
   // source select: instruction clock ignores sync select
   // crystal output chosen when the oscillator is on
   assign src_edge   = !st.ctrl[CTRL_CS] ? instr_tick
                     : (st.ctrl[CTRL_OSCEN] ? osc_rise : ext_rise);
   assign presc_done = (st.presc == ps_last(st.ctrl[CTRL_PS_LO +: 2]));
   // sync mode halts in sleep, async keeps going
   assign can_inc    = st.ctrl[CTRL_ON] & src_edge & presc_done
                     & (!sleep | async_mode);
   // trigger only in special-event compare mode
   // not gated by clock mode: keeping it out of async counting is left to software
   assign trig_reset = special_trigger & (st.cmp_mode == CMP_MODE_SPECIAL);

   // all updates of st in one place
   always_comb begin
      next_st      = st;
      next_st.conv = 1'b0;
      // prescaler runs on source edges even while asleep
      if (st.ctrl[CTRL_ON] & src_edge) begin
         next_st.presc = presc_done ? 3'h0 : st.presc + 3'h1;
      end
      // counting with wrap and overflow
      if (can_inc) begin
         next_st.count = st.count + 16'h0001;
         if (st.count == 16'hffff) begin
            next_st.ovf = 1'b1;
         end
      end
      // period reset from the compare unit, no flag raised
      if (trig_reset) begin
         next_st.count = 16'h0000;
         next_st.ovf   = st.ovf | (can_inc & (st.count == 16'hffff));
         next_st.conv  = st.ctrl[CTRL_ADEN];
      end
      // register writes; placed last so a write beats the trigger
      if (wr) begin
         unique case (paddr)
            ADDR_LOW: begin
               next_st.count[7:0] = pwdata[7:0];
               next_st.presc      = 3'h0;
               if (wide) begin
                  next_st.count[15:8] = st.hbuf;
               end else begin
                  next_st.count[15:8] = st.count[15:8]; // upper byte kept
               end
            end
            ADDR_HIGH: begin
               if (wide) begin
                  next_st.hbuf = pwdata[7:0]; // buffer only
               end else begin
                  next_st.count[15:8] = pwdata[7:0];
                  next_st.presc       = 3'h0;
               end
            end
            ADDR_CTRL:    next_st.ctrl     = pwdata[10:0];
            ADDR_STAT:    next_st.ovf      = st.ovf & ~pwdata[0] | (next_st.ovf & ~st.ovf);
            ADDR_CMP:     next_st.cmp      = pwdata[15:0];
            ADDR_CMPMODE: next_st.cmp_mode = pwdata[3:0];
            default: ;
         endcase
      end
      // reads: wide-mode low-byte read snapshots upper byte unless rmw
      if (rd && paddr == ADDR_LOW && wide && !st.ctrl[CTRL_RMW]) begin
         next_st.hbuf = st.count[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st          <= '0;
         st.ctrl     <= CTRL_RESET;
         st.cmp      <= CMP_RESET;
         st.cmp_mode <= CMP_MODE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // read data is combinational from live state so it is valid in the access cycle
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         unique case (paddr)
            ADDR_LOW:     prdata = {24'h000000, st.count[7:0]};
            ADDR_HIGH:    prdata = {24'h000000, wide ? st.hbuf : st.count[15:8]};
            ADDR_CTRL:    prdata = {21'h000000, st.ctrl};
            ADDR_STAT:    prdata = {31'h00000000, st.ovf};
            ADDR_CMP:     prdata = {16'h0000, st.cmp};
            ADDR_CMPMODE: prdata = {28'h0000000, st.cmp_mode};
            default:      prdata = 32'h0000_0000;
         endcase
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready        = 1'b1;
   assign pslverr       = acc & (paddr > ADDR_CMPMODE | paddr[1:0] != 2'b00);
   // oscillator enable ignores sleep
   assign osc_enable    = st.ctrl[CTRL_OSCEN];
   assign overflow_flag = st.ovf;
   assign irq           = st.ovf & st.ctrl[CTRL_IE];
   assign wake          = irq & sleep;
   assign conv_start    = st.conv;

   // helper: counter value one cycle back
   logic [15:0] prev_count;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_count <= 16'h0000;
      end else begin
         prev_count <= st.count;
      end
   end

   a_wide_hwrite: assert property (@(posedge pclk) disable iff (!presetn)
      wr && wide && paddr == ADDR_HIGH && !trig_reset && !can_inc
      |=> st.count[15:8] == $past(st.count[15:8]) && st.hbuf == $past(pwdata[7:0]))
      else $error("high write in wide mode touched counter");
   a_wide_lowwr: assert property (@(posedge pclk) disable iff (!presetn)
      wr && wide && paddr == ADDR_LOW |=> st.count == {$past(st.hbuf), $past(pwdata[7:0])})
      else $error("low write did not load buffer and byte");
   a_snap_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && wide && paddr == ADDR_LOW && !st.ctrl[CTRL_RMW] |=> st.hbuf == $past(st.count[15:8]))
      else $error("low read missed snapshot");
   a_rmw_keep: assert property (@(posedge pclk) disable iff (!presetn)
      rd && wide && paddr == ADDR_LOW && st.ctrl[CTRL_RMW] && !wr |=> $stable(st.hbuf))
      else $error("rmw read refreshed buffer");
   a_hw_presc: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_LOW |=> st.presc == 3'h0)
      else $error("low write did not clear prescaler");
   a_trig_zero: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reset && !wr |=> st.count == 16'h0000)
      else $error("trigger did not clear counter");
   a_trig_noflag: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reset && !wr && !st.ovf && !(can_inc && st.count == 16'hffff) |=> !st.ovf)
      else $error("trigger raised overflow");
   a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      can_inc && st.count == 16'hffff && !trig_reset && !wr |=> st.ovf && st.count == 16'h0000)
      else $error("wrap did not set overflow");
   a_sync_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      sleep && !async_mode && !wr && !trig_reset |=> st.count == prev_count)
      else $error("counter moved in sleep without async mode");
   a_wr_wins: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reset && wr && paddr == ADDR_LOW && !wide |=> st.count[7:0] == $past(pwdata[7:0]))
      else $error("trigger beat a write");

   // byte paths with the wide mode off and on
   a_narrow_hwrite: assert property (@(posedge pclk) disable iff (!presetn)
      wr && !wide && paddr == ADDR_HIGH |=> st.count[15:8] == $past(pwdata[7:0]))
      else $error("narrow high write missed counter");
   a_narrow_hread: assert property (@(posedge pclk) disable iff (!presetn)
      rd && !wide && paddr == ADDR_HIGH |-> prdata[7:0] == st.count[15:8])
      else $error("narrow high read not live");
   a_narrow_lowrd: assert property (@(posedge pclk) disable iff (!presetn)
      rd && !wide && paddr == ADDR_LOW |=> $stable(st.hbuf))
      else $error("narrow low read touched buffer");
   a_wide_hread: assert property (@(posedge pclk) disable iff (!presetn)
      rd && wide && paddr == ADDR_HIGH |-> prdata[7:0] == st.hbuf)
      else $error("wide high read bypassed buffer");
   a_hwr_presc: assert property (@(posedge pclk) disable iff (!presetn)
      wr && wide && paddr == ADDR_HIGH && !(st.ctrl[CTRL_ON] && src_edge)
      |=> $stable(st.presc))
      else $error("buffer write moved prescaler");

   // clock sources, sleep and overflow
   a_osc_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      st.ctrl[CTRL_OSCEN] && sleep && !wr |=> osc_enable)
      else $error("sleep stopped crystal oscillator");
   a_async_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      sleep && async_mode && st.ctrl[CTRL_ON] && src_edge && presc_done && !wr && !trig_reset
      |=> st.count == $past(st.count) + 16'h0001)
      else $error("async count stalled in sleep");
   a_wrap_irq: assert property (@(posedge pclk) disable iff (!presetn)
      can_inc && st.count == 16'hffff && st.ctrl[CTRL_IE] && !wr |=> irq)
      else $error("wrap with enable raised no interrupt");
   a_instr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !st.ctrl[CTRL_CS] && !instr_tick && !wr && !trig_reset |=> $stable(st.count))
      else $error("timer mode moved without instruction tick");
   a_osc_src: assert property (@(posedge pclk) disable iff (!presetn)
      st.ctrl[CTRL_ON] && st.ctrl[CTRL_CS] && st.ctrl[CTRL_OSCEN] && !osc_rise
      && !wr && !trig_reset |=> $stable(st.count) && $stable(st.presc))
      else $error("crystal mode moved without crystal edge");

   // conversion start follows the trigger reset and nothing else
   a_trig_conv: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reset && st.ctrl[CTRL_ADEN] |=> conv_start)
      else $error("trigger started no conversion");
   a_conv_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !(trig_reset && st.ctrl[CTRL_ADEN]) |=> !conv_start)
      else $error("conversion start without trigger");

   // cycles since the last instruction tick; a lost tick would slow timer mode
   logic [7:0] tick_gap;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_gap <= 8'h00;
      end else begin
         tick_gap <= instr_tick ? 8'h00 : tick_gap + 8'h01;
      end
   end
   a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
      tick_gap <= 8'(INSTR_DIV))
      else $error("instruction tick missing");

   c_wrap:  cover property (@(posedge pclk) can_inc && st.count == 16'hffff);
   c_trig:  cover property (@(posedge pclk) trig_reset);
   c_wide:  cover property (@(posedge pclk) rd && wide && paddr == ADDR_LOW);
   c_sleep: cover property (@(posedge pclk) sleep && async_mode && can_inc);
   c_rmw:   cover property (@(posedge pclk) rd && wide && paddr == ADDR_LOW && st.ctrl[CTRL_RMW]);
endmodule

// *** rtl/tmb_pkg.sv ***
// constants for the buffered-access 16-bit timer: register map, control fields, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
//
// How it works
// - wide mode maps the high-byte address onto a buffer register
// - wide mode low-byte read copies counter upper byte into buffer
// - wide mode high write fills buffer; low write loads buffer plus byte
// - wide mode gives no direct path to the counter upper byte
// - wide mode high write leaves prescaler alone; low write clears it
// - read-modify-write of low byte does not refresh buffer, writes it back
// - narrow mode async reads return clean synchronised byte values
// - crystal oscillator can clock counter; enable bit turns it on
// - sleep never stops the crystal oscillator
// - async mode counts in sleep, sets overflow flag, wakes if enabled
// - compare trigger with mode 1011 resets counter to zero
// - trigger reset never sets the overflow flag
// - a processor write beats a coincident trigger reset
// - with trigger reset the period is set by special_trigger; the compare pair is only stored, never compared
// - trigger may also start an analog conversion
// - counter wraps ffff to 0000, sets overflow flag, interrupt if enabled
// - clock source clear uses instruction clock, sync select ignored
// - sync mode stops counting in sleep while prescaler keeps counting
package tmb_pkg;
   localparam logic [11:0] ADDR_LOW     = 12'h000;
   localparam logic [11:0] ADDR_HIGH    = 12'h004;
   localparam logic [11:0] ADDR_CTRL    = 12'h008;
   localparam logic [11:0] ADDR_STAT    = 12'h00c;
   localparam logic [11:0] ADDR_CMP     = 12'h010;
   localparam logic [11:0] ADDR_CMPMODE = 12'h014;
   // control bit positions
   localparam int CTRL_ON    = 0;
   localparam int CTRL_CS    = 1;
   localparam int CTRL_SYNCN = 2;
   localparam int CTRL_OSCEN = 3;
   localparam int CTRL_PS_LO = 4;
   localparam int CTRL_WIDE  = 7;
   localparam int CTRL_RMW   = 8;
   localparam int CTRL_IE    = 9;
   localparam int CTRL_ADEN  = 10;
   localparam logic [10:0] CTRL_RESET = 11'h000;
   localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hb;
   localparam logic [3:0]  CMP_MODE_RESET   = 4'h0;
   localparam logic [15:0] CMP_RESET        = 16'hffff;
   localparam int INSTR_DIV = 4;
endpackage

// *** rtl/tmb_clkdiv.sv ***
// instruction-clock enable: one pulse every INSTR_DIV cycles of pclk
// assumes pclk stands for the oscillator rate
`timescale 1ns/1ps
module tmb_clkdiv
   import tmb_pkg::*;
#(
   parameter int DIV = INSTR_DIV
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } tmb_div_t;
   tmb_div_t st, next_st;

   // free running divide by DIV
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 8'(DIV - 1)) begin
         next_st.cnt  = 8'h00;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick = st.tick;
endmodule

// *** rtl/tmb_edge.sv ***
// two-flop synchroniser and rising-edge pulse for an external count input
// assumes the input is a level that may change at any time
`timescale 1ns/1ps
module tmb_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tmb_edge_t;
   tmb_edge_t st, next_st;

   // s1 feeds only s2; edge taken between s2 and s3
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign rise = st.s2 & ~st.s3;
endmodule

// *** tb/tmb_cpu.sv ***
// processor-side apb master driving the timer bytes
// assumes pready answers within 16 cycles of the access phase
`timescale 1ns/1ps
module tmb_cpu (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata
);
   // idle bus at time zero
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // one transfer; leading edge wait avoids a double assign of psel
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err, output bit ok);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      ok = (pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// *** tb/tmb_timer_tb_top.sv ***
// bench for the buffered-access timer: integer model compared at each read
// assumes zero-wait apb and pin edges counted 3 pclk after the rise
`timescale 1ns/1ps
module tmb_timer_tb_top;
   import tmb_pkg::*;
   localparam int ON = 1 << CTRL_ON;
   localparam int CS = 1 << CTRL_CS;
   localparam int SN = 1 << CTRL_SYNCN;
   localparam int OE = 1 << CTRL_OSCEN;
   localparam int WD = 1 << CTRL_WIDE;
   localparam int RM = 1 << CTRL_RMW;
   localparam int IE = 1 << CTRL_IE;
   localparam int AD = 1 << CTRL_ADEN;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        ext_clk_in, osc_clk_in, sleep, special_trigger;
   logic        osc_enable, overflow_flag, irq, wake, conv_start;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, r;
   logic [10:0] m_ctrl;
   logic        err;
   bit          ok;
   int          m_cnt, m_hbuf, m_ps, m_ovf, m_cmp, m_mode;
   int          n_mismatch, num_checks, conv_seen, i;
   tmb_timer tmb_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
      .osc_clk_in(osc_clk_in), .sleep(sleep), .special_trigger(special_trigger),
      .osc_enable(osc_enable), .overflow_flag(overflow_flag), .irq(irq),
      .wake(wake), .conv_start(conv_start));
   tmb_cpu tmb_cpu_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // conversion pulses counted for the trigger scenario
   always @(posedge pclk) begin
      if (conv_start === 1'b1) conv_seen++;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
         n_mismatch++;
      end
   endtask
   // read through the cpu, expectation from the model
   task automatic rd(input logic [11:0] a);
      logic [31:0] e;
      bit          ee;
      ee = 1'b0;
      tmb_cpu_inst.xfer(1'b0, a, 32'h0, q, err, ok);
      if (!ok) n_mismatch++;
      if (!ok) summarize();
      case (a)
         ADDR_LOW: begin
            e = m_cnt & 'hff;
            if (m_ctrl[CTRL_WIDE] && !m_ctrl[CTRL_RMW]) m_hbuf = m_cnt >> 8;
         end
         ADDR_HIGH: e = m_ctrl[CTRL_WIDE] ? m_hbuf : m_cnt >> 8;
         ADDR_CTRL: e = m_ctrl;
         ADDR_STAT: e = m_ovf;
         ADDR_CMP: e = m_cmp;
         ADDR_CMPMODE: e = m_mode;
         default: begin
            e = 0;
            ee = 1'b1;
         end
      endcase
      chk("prdata", e, q);
      chk("pslverr", ee, err);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bit ee;
      ee = 1'b0;
      tmb_cpu_inst.xfer(1'b1, a, d, q, err, ok);
      if (!ok) n_mismatch++;
      if (!ok) summarize();
      case (a)
         ADDR_LOW: begin
            m_cnt = m_ctrl[CTRL_WIDE] ? (m_hbuf << 8) | d[7:0] : (m_cnt & 'hff00) | d[7:0];
            m_ps = 0;
         end
         ADDR_HIGH: begin
            if (m_ctrl[CTRL_WIDE]) m_hbuf = d[7:0];
            else begin
               m_cnt = (d[7:0] << 8) | (m_cnt & 'hff);
               m_ps = 0;
            end
         end
         ADDR_CTRL: m_ctrl = d[10:0];
         ADDR_STAT: if (d[0]) m_ovf = 0;
         ADDR_CMP: m_cmp = d[15:0];
         ADDR_CMPMODE: m_mode = d[3:0];
         default: ee = 1'b1;
      endcase
      chk("pslverr", ee, err);
   endtask
   // one rising edge on a count pin; sync mode in sleep only moves the prescaler
   task automatic pulse(input bit osc);
      if (osc) osc_clk_in <= 1'b1;
      else ext_clk_in <= 1'b1;
      repeat (3) @(posedge pclk);
      osc_clk_in <= 1'b0;
      ext_clk_in <= 1'b0;
      repeat (8) @(posedge pclk);
      if (m_ctrl[CTRL_ON] && m_ctrl[CTRL_CS] && osc == m_ctrl[CTRL_OSCEN]) begin
         m_ps++;
         // prescaler wraps even while sync mode stalls the count in sleep
         if (m_ps >= (1 << m_ctrl[5:4])) begin
            m_ps = 0;
            if (!(sleep && !m_ctrl[CTRL_SYNCN])) begin
               m_cnt = (m_cnt + 1) & 'hffff;
               if (m_cnt == 0) m_ovf = 1;
            end
         end
      end
   endtask
   task automatic trig;
      special_trigger <= 1'b1;
      @(posedge pclk);
      special_trigger <= 1'b0;
      repeat (3) @(posedge pclk);
      if (m_mode == CMP_MODE_SPECIAL) m_cnt = 0;
   endtask
   initial begin
      {presetn, ext_clk_in, osc_clk_in, sleep, special_trigger} = '0;
      {m_ctrl, m_cnt, m_hbuf, m_ps, m_ovf, m_mode} = '0;
      m_cmp = CMP_RESET;
      void'($urandom(32'hd984));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and refused addresses
      rd(ADDR_CTRL);
      rd(ADDR_STAT);
      rd(ADDR_CMP);
      rd(ADDR_CMPMODE);
      rd(12'h018);
      rd(12'h001);
      wr(12'h018, 32'h5a);
      for (i = 0; i < 4; i++) begin
         r = $urandom;
         wr(ADDR_HIGH, r[15:8]);
         wr(ADDR_LOW, r[7:0]);
         rd(ADDR_HIGH);
         rd(ADDR_LOW);
      end
      // wide mode: buffer stands in for the upper byte
      wr(ADDR_CTRL, WD);
      wr(ADDR_HIGH, 8'hab);
      rd(ADDR_HIGH);
      rd(ADDR_LOW);
      rd(ADDR_HIGH);
      r = $urandom;
      wr(ADDR_HIGH, r[15:8]);
      rd(ADDR_HIGH);
      wr(ADDR_LOW, r[7:0]);
      wr(ADDR_CTRL, 0);
      rd(ADDR_HIGH);
      rd(ADDR_LOW);
      wr(ADDR_CTRL, WD | RM);
      wr(ADDR_HIGH, 8'h9a);
      rd(ADDR_LOW);
      rd(ADDR_HIGH);
      wr(ADDR_LOW, 8'h11);
      wr(ADDR_CTRL, 0);
      rd(ADDR_HIGH);
      // prescaler 1:2 kept by a buffer write, cleared by a low write
      wr(ADDR_CTRL, ON | CS | WD | 32'h10);
      wr(ADDR_HIGH, 0);
      wr(ADDR_LOW, 0);
      pulse(0);
      wr(ADDR_HIGH, 0);
      pulse(0);
      rd(ADDR_LOW);
      pulse(0);
      wr(ADDR_LOW, 0);
      pulse(0);
      rd(ADDR_LOW);
      // wrap with interrupt; load done while stopped
      wr(ADDR_CTRL, CS | IE);
      wr(ADDR_HIGH, 8'hff);
      wr(ADDR_LOW, 8'hfe);
      wr(ADDR_CTRL, ON | CS | IE);
      pulse(0);
      chk("overflow_flag", 0, overflow_flag);
      pulse(0);
      rd(ADDR_HIGH);
      rd(ADDR_STAT);
      chk("irq", 1, irq);
      wr(ADDR_STAT, 1);
      @(negedge pclk); // clear lands at the access edge
      chk("irq", 0, irq);
      // async counting in sleep wakes the core
      wr(ADDR_CTRL, CS | SN | IE);
      wr(ADDR_HIGH, 8'hff);
      wr(ADDR_LOW, 8'hff);
      wr(ADDR_CTRL, ON | CS | SN | IE);
      sleep <= 1'b1;
      pulse(0);
      chk("wake", 1, wake);
      sleep <= 1'b0;
      for (i = 0; i < 3; i++) begin
         pulse(0);
         rd(ADDR_HIGH);
         rd(ADDR_LOW);
         rd(ADDR_HIGH);
      end
      wr(ADDR_STAT, 1);
      // sync counting halts in sleep
      wr(ADDR_CTRL, ON | CS);
      sleep <= 1'b1;
      pulse(0);
      sleep <= 1'b0;
      rd(ADDR_LOW);
      wr(ADDR_CTRL, CS);
      wr(ADDR_LOW, 0);
      // crystal input replaces the pin and survives sleep
      wr(ADDR_CTRL, ON | CS | SN | OE);
      @(negedge pclk); // control write lands at the access edge
      chk("osc_enable", 1, osc_enable);
      repeat (20) @(posedge pclk);
      pulse(0);
      pulse(1);
      rd(ADDR_LOW);
      sleep <= 1'b1;
      pulse(1);
      chk("osc_enable", 1, osc_enable);
      sleep <= 1'b0;
      rd(ADDR_LOW);
      // running bytewise load
      wr(ADDR_CTRL, ON | CS);
      r = $urandom;
      wr(ADDR_LOW, 0);
      wr(ADDR_HIGH, r[15:8]);
      wr(ADDR_LOW, r[7:0]);
      rd(ADDR_HIGH);
      // trigger reset, flag untouched, conversion start, write wins
      wr(ADDR_CTRL, CS | AD);
      trig();
      rd(ADDR_HIGH);
      wr(ADDR_CMPMODE, CMP_MODE_SPECIAL);
      wr(ADDR_CMP, 16'h0100);
      rd(ADDR_CMP);
      conv_seen = 0;
      trig();
      rd(ADDR_HIGH);
      rd(ADDR_STAT);
      chk("overflow_flag", 0, overflow_flag);
      chk("conv_start", 1, conv_seen);
      special_trigger <= 1'b1;
      m_cnt = 0;
      wr(ADDR_LOW, 8'h55);
      special_trigger <= 1'b0;
      rd(ADDR_LOW);
      // instruction clock: pclk/4, sync select ignored
      wr(ADDR_CMPMODE, 0);
      wr(ADDR_HIGH, 0);
      wr(ADDR_LOW, 0);
      wr(ADDR_CTRL, ON | SN);
      repeat (40) @(posedge pclk);
      wr(ADDR_CTRL, 0);
      tmb_cpu_inst.xfer(1'b0, ADDR_LOW, 32'h0, q, err, ok);
      chk("timer count", 1, q >= 9 && q <= 12);
      summarize();
   end
endmodule
